// File: rtl/spc_defs.svh
// Register offsets, field positions, reset values and divider counts of the serial port.
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH

`define SPC_OFF_CTRL 8'h00
`define SPC_OFF_FRM 8'h04
`define SPC_OFF_TX 8'h08
`define SPC_OFF_RX 8'h0c
`define SPC_OFF_STAT 8'h10

`define SPC_CTRL_RST 16'h0000
`define SPC_FRM_RST 16'h0000
`define SPC_CTRL_WMASK 16'h1fff
`define SPC_FRM_WMASK 16'he002

`define SPC_STAT_BUSY 0
`define SPC_STAT_RXFULL 1

`define SPC_WORD_BITS 5'h10
`define SPC_BYTE_BITS 5'h08

`define SPC_PRI_DIV3 10'h001
`define SPC_PRI_DIV2 10'h004
`define SPC_PRI_DIV1 10'h010
`define SPC_PRI_DIV0 10'h040

`endif

// File: rtl/spc_pkg.sv
// Types shared by the serial port control logic.
package spc_pkg;

  typedef struct packed {
    logic [2:0] unused;
    logic clock_pin_release;
    logic data_out_pin_release;
    logic word_width_select;
    logic sample_phase_select;
    logic clock_edge_select;
    logic slave_select_use;
    logic clock_idle_polarity;
    logic master_enable;
    logic [2:0] secondary_prescale;
    logic [1:0] primary_prescale;
  } spc_ctrl_t;

  typedef struct packed {
    logic framed_operation_enable;
    logic frame_sync_direction;
    logic frame_sync_polarity;
    logic [10:0] unused;
    logic frame_sync_edge_select;
    logic spare;
  } spc_frm_t;

  typedef enum logic [1:0] {
    SPC_IDLE,
    SPC_WAITFS,
    SPC_FRAME,
    SPC_SHIFT
  } spc_state_t;

endpackage

// File: rtl/spc_port.sv
// Serial peripheral port: APB registers on mclk, shift engine on the link clock.
//
// Notes on behaviour
// - Data-out release set frees the data pin; clear, the port drives it.
// - Master: sample at end of bit time when set, middle when clear.
// - Slave with select use set honours the select pin, else ignores it.
// - Clock polarity sets serial clock idle level; active is the opposite.
// - Framed master: direction set takes sync pulse as input, clear drives it.
`include "spc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module spc_port (
  input wire logic mclk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic lclk, // Link clock for the shift engine.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire logic sdi_i, // Serial data in pin.
  output logic sdo_o, // Serial data out pin value.
  output logic sdo_oe_n, // Serial data out enable, low drives.
  input wire logic sck_i, // Serial clock pin level.
  output logic sck_o, // Serial clock pin value.
  output logic sck_oe_n, // Serial clock enable, low drives.
  input wire logic ss_n_i, // Slave select pin, active low.
  input wire logic fs_i, // Frame sync pin level.
  output logic fs_o, // Frame sync pin value.
  output logic fs_oe_n // Frame sync enable, low drives.
);

  // ****************************************
  // Register file on mclk
  // ****************************************

  spc_pkg::spc_ctrl_t ctrl;
  spc_pkg::spc_frm_t frm;
  logic [15:0] tx_word;
  logic [15:0] rx_word;
  logic busy;
  logic rx_full;
  logic req_tgl;
  logic [2:0] done_sync;
  logic [15:0] rx_hold;
  logic done_tgl;

  logic acc;
  logic wr;
  logic rd;
  logic done_evt;
  logic mapped;

  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign done_evt = done_sync[2] ^ done_sync[1];
  assign mapped = (paddr == `SPC_OFF_CTRL) | (paddr == `SPC_OFF_FRM) |
    (paddr == `SPC_OFF_TX) | (paddr == `SPC_OFF_RX) | (paddr == `SPC_OFF_STAT);

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable)
      begin
        unique case (paddr)
          `SPC_OFF_CTRL: prdata <= {16'h0000, ctrl};
          `SPC_OFF_FRM: prdata <= {16'h0000, frm};
          `SPC_OFF_TX: prdata <= {16'h0000, tx_word};
          `SPC_OFF_RX: prdata <= {16'h0000, rx_word};
          `SPC_OFF_STAT: prdata <= {30'h00000000, rx_full, busy};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctrl <= `SPC_CTRL_RST;
      frm <= `SPC_FRM_RST;
    end
    else if (wr && paddr == `SPC_OFF_CTRL)
    begin
      ctrl <= pwdata[15:0] & `SPC_CTRL_WMASK;
    end
    else if (wr && paddr == `SPC_OFF_FRM)
    begin
      frm <= pwdata[15:0] & `SPC_FRM_WMASK;
    end
  end

  // A transmit word written while a transfer runs is dropped.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tx_word <= 16'h0000;
      req_tgl <= 1'b0;
      busy <= 1'b0;
    end
    else if (wr && paddr == `SPC_OFF_TX && !busy)
    begin
      tx_word <= pwdata[15:0];
      req_tgl <= ~req_tgl;
      busy <= 1'b1;
    end
    else if (done_evt)
    begin
      busy <= 1'b0;
    end
  end

  // A finished word sets the full flag even in the cycle it is read.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      done_sync <= 3'h0;
      rx_word <= 16'h0000;
      rx_full <= 1'b0;
    end
    else
    begin
      done_sync <= {done_sync[1:0], done_tgl};
      if (done_evt)
      begin
        rx_word <= rx_hold;
        rx_full <= 1'b1;
      end
      else if (rd && paddr == `SPC_OFF_RX)
      begin
        rx_full <= 1'b0;
      end
    end
  end

  // ****************************************
  // Crossings into the link domain
  // ****************************************

  logic [1:0] lrst_sync;
  logic lrst;
  logic [31:0] cfg_s1;
  logic [31:0] cfg_s2;
  logic [2:0] req_sync;
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic sck_prev;

  assign lrst = lrst_sync[1];

  always_ff @(posedge lclk)
  begin
    lrst_sync <= {lrst_sync[0], rst};
  end

  // Configuration is static while software follows the setup order.
  always_ff @(posedge lclk)
  begin
    cfg_s1 <= {frm, ctrl};
    cfg_s2 <= cfg_s1;
    req_sync <= {req_sync[1:0], req_tgl};
    pin_s1 <= {fs_i, ss_n_i, sck_i, sdi_i};
    pin_s2 <= pin_s1;
    sck_prev <= pin_s2[1];
  end

  // ****************************************
  // Shift engine on lclk
  // ****************************************

  spc_pkg::spc_ctrl_t lc;
  spc_pkg::spc_frm_t lf;
  spc_pkg::spc_state_t st;
  logic sdi_s;
  logic sck_s;
  logic ss_n_s;
  logic fs_s;
  logic [15:0] sh;
  logic [15:0] rxs;
  logic [15:0] next_rx;
  logic [4:0] bits;
  logic [4:0] nbits;
  logic [9:0] hc;
  logic [9:0] hp;
  logic [9:0] pri;
  logic [9:0] sec;
  logic half;
  logic pend;
  logic go;
  logic fs_act;
  logic sel_ok;
  logic lead;
  logic trail;
  logic tick;
  logic [15:0] load;
  logic mode_prev;

  assign lc = cfg_s2[15:0];
  assign lf = cfg_s2[31:16];
  assign {fs_s, ss_n_s, sck_s, sdi_s} = pin_s2;
  assign next_rx = {rxs[14:0], sdi_s};
  assign nbits = lc.word_width_select ? `SPC_WORD_BITS : `SPC_BYTE_BITS;
  assign load = lc.word_width_select ? tx_word : {tx_word[7:0], 8'h00};
  assign go = pend | (req_sync[2] ^ req_sync[1]);
  assign fs_act = fs_s == lf.frame_sync_polarity;
  assign sel_ok = ~(lc.slave_select_use & ss_n_s);
  assign lead = (sck_s != lc.clock_idle_polarity) && (sck_prev == lc.clock_idle_polarity);
  assign trail = (sck_s == lc.clock_idle_polarity) && (sck_prev != lc.clock_idle_polarity);
  assign tick = hc == 10'h000;

  // A half bit of two link clocks is too short for a middle sample: the input
  // synchroniser delays the data pin by that much, so use three or more there.
  always_comb
  begin
    unique case (lc.primary_prescale)
      2'h3: pri = `SPC_PRI_DIV3;
      2'h2: pri = `SPC_PRI_DIV2;
      2'h1: pri = `SPC_PRI_DIV1;
      2'h0: pri = `SPC_PRI_DIV0;
    endcase
    sec = {7'h00, ~lc.secondary_prescale} + 10'h001;
    hp = 10'((pri * sec) - 10'h001);
  end

  // Mode of the previous cycle, so that a change of mode can drop a half-done word.
  always_ff @(posedge lclk)
  begin
    if (lrst)
    begin
      mode_prev <= 1'b0;
    end
    else
    begin
      mode_prev <= lc.master_enable;
    end
  end

  // Word pending from the register side until the engine takes it.
  always_ff @(posedge lclk)
  begin
    if (lrst)
    begin
      pend <= 1'b0;
    end
    else
    begin
      pend <= go & ((st != spc_pkg::SPC_IDLE) | (lc.master_enable != mode_prev));
    end
  end

  always_ff @(posedge lclk)
  begin
    if (lrst)
    begin
      st <= spc_pkg::SPC_IDLE;
      sh <= 16'h0000;
      rxs <= 16'h0000;
      rx_hold <= 16'h0000;
      bits <= 5'h00;
      hc <= 10'h000;
      half <= 1'b0;
      sck_o <= 1'b0;
      fs_o <= 1'b0;
      done_tgl <= 1'b0;
    end
    else if (lc.master_enable != mode_prev)
    begin
      // An armed slave must not turn into a master transfer nobody asked for.
      st <= spc_pkg::SPC_IDLE;
      sck_o <= lc.clock_idle_polarity;
      fs_o <= ~lf.frame_sync_polarity;
    end
    else if (lc.master_enable)
    begin
      unique case (st)
        spc_pkg::SPC_IDLE:
        begin
          sck_o <= lc.clock_idle_polarity;
          fs_o <= ~lf.frame_sync_polarity;
          hc <= hp;
          half <= 1'b0;
          bits <= nbits;
          if (go)
          begin
            sh <= load;
            if (lf.framed_operation_enable && lf.frame_sync_direction)
            begin
              st <= spc_pkg::SPC_WAITFS;
            end
            else if (lf.framed_operation_enable)
            begin
              fs_o <= lf.frame_sync_polarity;
              st <= lf.frame_sync_edge_select ? spc_pkg::SPC_SHIFT : spc_pkg::SPC_FRAME;
            end
            else
            begin
              st <= spc_pkg::SPC_SHIFT;
            end
          end
        end
        spc_pkg::SPC_WAITFS:
        begin
          if (fs_act)
          begin
            st <= spc_pkg::SPC_SHIFT;
          end
        end
        spc_pkg::SPC_FRAME:
        begin
          hc <= tick ? hp : hc - 10'h001;
          if (tick)
          begin
            half <= ~half;
            if (half)
            begin
              fs_o <= ~lf.frame_sync_polarity;
              st <= spc_pkg::SPC_SHIFT;
            end
          end
        end
        spc_pkg::SPC_SHIFT:
        begin
          hc <= tick ? hp : hc - 10'h001;
          if (tick && !half)
          begin
            half <= 1'b1;
            sck_o <= ~lc.clock_idle_polarity;
            if (!lc.sample_phase_select)
            begin
              rxs <= next_rx;
            end
          end
          else if (tick)
          begin
            half <= 1'b0;
            sck_o <= lc.clock_idle_polarity;
            fs_o <= ~lf.frame_sync_polarity;
            if (lc.sample_phase_select)
            begin
              rxs <= next_rx;
            end
            if (bits == 5'h01)
            begin
              rx_hold <= lc.sample_phase_select ? next_rx : rxs;
              done_tgl <= ~done_tgl;
              st <= spc_pkg::SPC_IDLE;
            end
            else
            begin
              bits <= bits - 5'h01;
              sh <= {sh[14:0], 1'b0};
            end
          end
        end
      endcase
    end
    else
    begin
      sck_o <= lc.clock_idle_polarity;
      fs_o <= ~lf.frame_sync_polarity;
      unique case (st)
        spc_pkg::SPC_IDLE:
        begin
          bits <= nbits;
          if (go)
          begin
            sh <= load;
          end
          if (sel_ok && (!lf.framed_operation_enable || fs_act))
          begin
            st <= spc_pkg::SPC_SHIFT;
          end
        end
        spc_pkg::SPC_SHIFT:
        begin
          if (!sel_ok)
          begin
            st <= spc_pkg::SPC_IDLE;
          end
          else if (lead)
          begin
            rxs <= next_rx;
          end
          else if (trail && bits == 5'h01)
          begin
            rx_hold <= rxs;
            done_tgl <= ~done_tgl;
            st <= spc_pkg::SPC_IDLE;
          end
          else if (trail)
          begin
            bits <= bits - 5'h01;
            sh <= {sh[14:0], 1'b0};
          end
        end
        default:
        begin
          st <= spc_pkg::SPC_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************

  always_ff @(posedge lclk)
  begin
    if (lrst)
    begin
      sdo_o <= 1'b0;
      sdo_oe_n <= 1'b1;
      sck_oe_n <= 1'b1;
      fs_oe_n <= 1'b1;
    end
    else
    begin
      sdo_o <= sh[15];
      sdo_oe_n <= lc.data_out_pin_release;
      sck_oe_n <= ~(lc.master_enable & ~lc.clock_pin_release);
      fs_oe_n <= ~(lc.master_enable & lf.framed_operation_enable &
        ~lf.frame_sync_direction);
    end
  end

endmodule

`default_nettype wire

// File: dv/spc_port_checker.sv
// Checker of the serial port bus answers and pin enables.
`include "spc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module spc_port_checker (
  input wire logic mclk, // Clock.
  input wire logic rst, // Reset.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic pwrite, // Write.
  input wire logic [7:0] paddr, // Address.
  input wire logic [31:0] pwdata, // Wdata.
  input wire logic [31:0] prdata, // Rdata.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error.
  input wire logic sdo_oe_n, // Data enable.
  input wire logic sck_oe_n, // Clock enable.
  input wire logic fs_oe_n // Sync enable.
);
  spc_pkg::spc_ctrl_t ctrl;
  spc_pkg::spc_frm_t frm;
  logic [7:0] quiet;
  logic wr;
  assign wr = psel && penable && pready && pwrite;
  // Pins are judged only once the link side has seen the last setup write.
  always_ff @(posedge mclk)
  begin
    if (rst || (wr && paddr inside {`SPC_OFF_CTRL, `SPC_OFF_FRM})) quiet <= 8'h00;
    else if (quiet != 8'hff) quiet <= quiet + 8'h01;
  end
  always_ff @(posedge mclk)
  begin
    if (rst) ctrl <= '0;
    else if (wr && paddr == `SPC_OFF_CTRL) ctrl <= pwdata[15:0] & `SPC_CTRL_WMASK;
  end
  always_ff @(posedge mclk)
  begin
    if (rst) frm <= '0;
    else if (wr && paddr == `SPC_OFF_FRM) frm <= pwdata[15:0] & `SPC_FRM_WMASK;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_READY_NEXT: assert property (psel && !penable |=> pready) else $error("ready late");
  AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready held");
  AST_ERR_ONLY: assert property (pslverr |-> pready) else $error("error alone");
  AST_ERR_UNMAPPED: assert property (pready && paddr > 8'h10 |-> pslverr) else $error("no error");
  AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper bits set");
  AST_DATA_PIN:
    assert property (quiet == 8'hff |-> sdo_oe_n == ctrl.data_out_pin_release)
    else $error("data pin enable");
  AST_CLOCK_PIN:
    assert property (quiet == 8'hff |-> sck_oe_n == !(ctrl.master_enable && !ctrl.clock_pin_release))
    else $error("clock pin enable");
  AST_SYNC_PIN:
    assert property (quiet == 8'hff && frm.framed_operation_enable
      |-> fs_oe_n == !(ctrl.master_enable && !frm.frame_sync_direction))
    else $error("sync pin enable");
  C_ERR: cover property (pslverr);
  C_SYNC_OUT: cover property (quiet == 8'hff && !fs_oe_n);
  C_TX: cover property (wr && paddr == `SPC_OFF_TX);
endmodule
`default_nettype wire

// File: dv/spc_peer.sv
// Serial peer: takes a bit on each active clock edge, shifts its reply on each return to idle.
`timescale 1ns/1ps
`default_nettype none
module spc_peer (
  input wire logic sck, // Clock line.
  input wire logic pol, // Idle level.
  input wire logic sdo, // Data from port.
  input wire logic load, // Load reply.
  input wire logic [15:0] word, // Reply, first bit left.
  output logic sdi, // Data to port.
  output logic [15:0] got // Bits taken.
);
  logic [15:0] sh;
  assign sdi = sh[15];
  always @(posedge load) sh = word;
  // Spent bits are refilled inverted so stale data never looks valid.
  always @(sck)
    if (sck !== pol) got = {got[14:0], sdo};
    else sh = {sh[14:0], ~sh[0]};
endmodule
`default_nettype wire

// File: dv/tb_spi_port_control_framing.sv
// Testbench of the serial port: registers, transfers and pin enables.
`include "spc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_spi_port_control_framing;
  logic mclk, lclk, rst, psel, penable, pwrite, pready, pslverr, rerr, pol, load, fsi;
  logic sdi, sdo, sdo_oe_n, sck, sck_o, sck_oe_n, fs_o, fs_oe_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [15:0] word, got;
  int num_errors = 0;
  int samples_checked = 0;
  assign sck = sck_oe_n ? pol : sck_o;
  spc_port spc_port_i (.mclk(mclk), .rst(rst), .lclk(lclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_n(sdo_oe_n), .sck_i(sck),
    .sck_o(sck_o), .sck_oe_n(sck_oe_n), .ss_n_i(1'h1), .fs_i(fsi), .fs_o(fs_o),
    .fs_oe_n(fs_oe_n));
  spc_peer spc_peer_i (.sck(sck), .pol(pol), .sdo(sdo), .load(load), .word(word),
    .sdi(sdi), .got(got));
  initial
  begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    lclk = 1'h0;
    #37;
    forever #80 lclk = ~lclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'h1 && n < 64);
    rdata = prdata;
    rerr = pslverr;
    if (pready !== 1'h1) chk(32'h0, 32'h1, "no answer");
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
    input string s);
    apb(1'h0, a, 32'h0);
    chk(rdata & m, e, s);
  endtask
  task automatic t_regs;
    chk(32'({sdo_oe_n, sck_oe_n, fs_oe_n}), 32'h7, "pins reset");
    rd(`SPC_OFF_CTRL, 32'h0, 32'hffffffff, "ctrl reset");
    rd(`SPC_OFF_FRM, 32'h0, 32'hffffffff, "frm reset");
    apb(1'h1, `SPC_OFF_FRM, 32'hfffffffe);
    rd(`SPC_OFF_FRM, 32'he002, 32'hffffffff, "frm bits");
    apb(1'h1, `SPC_OFF_FRM, 32'h0);
    apb(1'h1, `SPC_OFF_CTRL, 32'hfffffffe);
    rd(`SPC_OFF_CTRL, 32'h1ffe, 32'hffffffff, "ctrl bits");
    apb(1'h1, 8'h40, 32'hffffffff);
    chk(32'(rerr), 32'h1, "unmapped write");
    rd(8'h40, 32'h0, 32'hffffffff, "unmapped read");
    chk(32'(rerr), 32'h1, "unmapped error");
    $display("registers done");
  endtask
  task automatic t_xfer(input logic [31:0] c, input logic [15:0] tx, input logic [15:0] rep,
    input logic [15:0] m, input logic [31:0] f);
    int n;
    logic seen;
    pol <= c[6];
    apb(1'h1, `SPC_OFF_FRM, f);
    apb(1'h1, `SPC_OFF_CTRL, c);
    repeat (400) @(posedge mclk);
    word <= (m == 16'hffff) ? rep : {rep[7:0], 8'h00};
    load <= 1'h1;
    apb(1'h1, `SPC_OFF_TX, {16'h0, tx});
    load <= 1'h0;
    if (f[14])
    begin
      repeat (400) @(posedge mclk);
      rd(`SPC_OFF_STAT, 32'h1, 32'h3, "waits for sync");
      fsi <= f[13];
    end
    n = 0;
    seen = 1'h0;
    do
    begin
      apb(1'h0, `SPC_OFF_STAT, 32'h0);
      seen = seen | (fs_o === f[13]);
      n++;
    end
    while (rdata[`SPC_STAT_BUSY] !== 1'h0 && n < 4000);
    if (rdata[`SPC_STAT_BUSY] !== 1'h0) chk(32'h0, 32'h1, "busy stuck");
    chk(32'(seen), 32'(f[15] && !f[14]), "sync pulse");
    chk(32'(fs_o), 32'(!f[13]), "sync idle");
    rd(`SPC_OFF_STAT, 32'h2, 32'h3, "full");
    rd(`SPC_OFF_RX, {16'h0, rep & m}, {16'h0, m}, "rx word");
    chk({16'h0, got & m}, {16'h0, tx & m}, "tx word");
    chk(32'(sck), 32'(c[6]), "clock idle");
    rd(`SPC_OFF_STAT, 32'h0, 32'h3, "full clear");
    fsi <= 1'h0;
    $display("transfer done");
  endtask
  task automatic t_pins;
    apb(1'h1, `SPC_OFF_CTRL, 32'h183b);
    repeat (400) @(posedge mclk);
    chk(32'({sdo_oe_n, sck_oe_n}), 32'h3, "released");
    apb(1'h1, `SPC_OFF_CTRL, 32'h1b);
    repeat (400) @(posedge mclk);
    chk(32'({sdo_oe_n, sck_oe_n}), 32'h1, "slave");
    apb(1'h1, `SPC_OFF_CTRL, 32'h3b);
    apb(1'h1, `SPC_OFF_FRM, 32'h8000);
    repeat (400) @(posedge mclk);
    chk(32'(fs_oe_n), 32'h0, "sync out");
    apb(1'h1, `SPC_OFF_FRM, 32'hc000);
    repeat (400) @(posedge mclk);
    chk(32'(fs_oe_n), 32'h1, "sync in");
    $display("pins done");
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #100us;
    num_errors++;
    $display("[FAIL] %0t timeout", $time);
    give_verdict();
  end
  initial
  begin
    {rst, psel, penable, pwrite, load, pol, fsi} = 7'h40;
    {paddr, pwdata, word} = '0;
    repeat (10) @(posedge lclk);
    @(posedge mclk);
    rst <= 1'h0;
    t_regs();
    t_xfer(32'h77, 16'h00a5, 16'h003c, 16'h00ff, 32'h0);
    t_xfer(32'h63b, 16'hc3a1, 16'h5e69, 16'hffff, 32'h0);
    t_xfer(32'h77, 16'h005a, 16'h0096, 16'h00ff, 32'ha000);
    t_xfer(32'h63b, 16'h1e2d, 16'hb4c7, 16'hffff, 32'he000);
    t_pins();
    give_verdict();
  end
endmodule
bind spc_port spc_port_checker spc_port_checker_i (.mclk(mclk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sdo_oe_n(sdo_oe_n), .sck_oe_n(sck_oe_n),
  .fs_oe_n(fs_oe_n));
`default_nettype wire
